/* File: spm_pkg.sv */
// Package for the switch power-mode state machine and its host end
package spm_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ          = 50_000_000;
  localparam int LPM_HOLD_US     = 500;
  localparam int LPM_HOLD_CYC    = (LPM_HOLD_US * (CLK_HZ / 1_000_000)) + 1;
  localparam int INP_LAG_US      = 10;
  localparam int INP_LAG_CYC     = INP_LAG_US * (CLK_HZ / 1_000_000);
  localparam int RETRY_CYCLES    = 32;
  localparam int RETRY_HALF_CYC  = 64;
  localparam int FLT_DELAY_CYC   = 16;
  localparam int MAIN_ON_CYC     = 8;
  localparam int CNT_W           = 16;

  // ****************************************************************
  // Operating modes
  // ****************************************************************
  typedef enum logic [2:0] {
    SPM_POWERDOWN = 3'b000,
    SPM_SHUTDOWN  = 3'b001,
    SPM_ACTIVE    = 3'b011,
    SPM_LOWPOWER  = 3'b010,
    SPM_WAKEUP    = 3'b110,
    SPM_FAULT     = 3'b111
  } spm_mode_t;

endpackage

/* File: spm_link_if.sv */
// Pins between the switch controller and its host
`timescale 1ns/1ps
`default_nettype none
interface spm_link_if;
  logic enable_undervoltage_input;
  logic low_power_request_n;
  logic main_switch_input;
  logic fault_output_n;
  logic wake_output;

  modport device (
    input  enable_undervoltage_input,
    input  low_power_request_n,
    input  main_switch_input,
    output fault_output_n,
    output wake_output
  );

  modport host (
    output enable_undervoltage_input,
    output low_power_request_n,
    output main_switch_input,
    input  fault_output_n,
    input  wake_output
  );
endinterface
`default_nettype wire

/* File: spm_sync.sv */
// Two-flop synchroniser bank for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module spm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          meta_r[i] <= 1'b0;
          q[i]      <= 1'b0;
        end else begin
          meta_r[i] <= d[i];
          q[i]      <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: spm_device.sv */
// Operating-mode state machine of the high-side switch controller
// Summary of operation
// (RULE1) Enable below threshold drops both gates
// (RULE2) Supply below power-on: all off
// (RULE3) Supply good, enable low: shutdown
// (RULE4) Enable plus request over 500us: low power
// (RULE5) Enable with request released: straight active
// (RULE6) Active plus request: go low power
// (RULE7) Host drops switch 10us after request
// (RULE8) Low power: bypass on, main off, wake
// (RULE9) Low power, request released: go active
// (RULE10) Load wakeup: main on, bypass off, unwake
// (RULE11) Wakeup holds until request released
// (RULE12) Low power undervoltage drops bypass drive
// (RULE13) Low power pump undervoltage: bypass off, fault
// (RULE14) Bypass short before gate good: wakeup
// (RULE15) Wakeup short: both off, fault, retry
// (RULE16) Active: main follows switch, bypass off
// (RULE17) Active undervoltage drops main drive
// (RULE18) Active pump undervoltage: main off, fault
// (RULE19) Active overcurrent integrate: main off, fault
// (RULE20) Active main short: main off, fault
// (RULE21) Retry after 32 timer cycles, delayed release
// (RULE22) Latch clears on switch fall, request, enable
// (RULE23) Synchronise inputs, time intervals by counter
`timescale 1ns/1ps
`default_nettype none
module spm_device
  import spm_pkg::*;
#(
  parameter int HOLD_CYC  = LPM_HOLD_CYC,
  parameter int RETRY_CNT = RETRY_CYCLES,
  parameter int HALF_CYC  = RETRY_HALF_CYC
) (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RESET_N,
  // Host pins
  spm_link_if.device LINK,
  // Analog comparator events
  input  wire logic POWERON_OK,
  input  wire logic UNDERVOLTAGE_OK,
  input  wire logic PUMP_OK,
  input  wire logic LOAD_WAKEUP_EVENT,
  input  wire logic BYPASS_SHORT_EVENT,
  input  wire logic BYPASS_GATE_GOOD,
  input  wire logic MAIN_SHORT_EVENT,
  input  wire logic OVERCURRENT_EXPIRED,
  input  wire logic MAIN_GATE_FULL,
  // Configuration
  input  wire logic LATCH_OFF_MODE,
  // Drive and status outputs
  output logic      MAIN_GATE_DRIVE,
  output logic      BYPASS_GATE_DRIVE,
  output logic      PUMP_ENABLE,
  output logic      PROTECT_ENABLE,
  output logic [2:0] MODE
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [11:0] raw_w;
  logic [11:0] syn_w;
  assign raw_w = {LINK.enable_undervoltage_input, LINK.low_power_request_n,
                  LINK.main_switch_input, POWERON_OK, UNDERVOLTAGE_OK,
                  PUMP_OK, LOAD_WAKEUP_EVENT, BYPASS_SHORT_EVENT,
                  BYPASS_GATE_GOOD, MAIN_SHORT_EVENT, OVERCURRENT_EXPIRED,
                  MAIN_GATE_FULL};

  // (RULE23) Two-flop sampling
  spm_sync #(.W(12)) u_sync (
    .clk     (CLK),
    .reset_n (RESET_N),
    .d       (raw_w),
    .q       (syn_w)
  );

  logic en_s, lpm_n_s, inp_s, por_s, uv_s, pump_s;
  logic lwu_s, bshort_s, bgood_s, mshort_s, ocp_s, mfull_s;
  assign {en_s, lpm_n_s, inp_s, por_s, uv_s, pump_s, lwu_s, bshort_s,
          bgood_s, mshort_s, ocp_s, mfull_s} = syn_w;

  // ****************************************************************
  // Edge history
  // ****************************************************************
  logic en_q_r, lpm_n_q_r, inp_q_r;
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      en_q_r    <= 1'b0;
      lpm_n_q_r <= 1'b1;
      inp_q_r   <= 1'b0;
    end else begin
      en_q_r    <= en_s;
      lpm_n_q_r <= lpm_n_s;
      inp_q_r   <= inp_s;
    end
  end
  wire en_rise  = en_s & ~en_q_r;
  wire inp_fall = ~inp_s & inp_q_r;
  wire lpm_fall = ~lpm_n_s & lpm_n_q_r;

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  spm_mode_t   state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [5:0]  retry_r;
  logic [4:0]  flt_dly_r;
  logic        fault_r;
  logic        retrying_r;

  // Fault trip of the active path: main short or overcurrent
  wire trip_act = mshort_s | ocp_s;
  wire clear_latch = inp_fall | lpm_fall | ~en_s;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SPM_POWERDOWN: if (por_s) state_nxt = SPM_SHUTDOWN;
      SPM_SHUTDOWN: begin
        // (RULE5) Both pins high together
        if (en_rise && lpm_n_s)
          state_nxt = SPM_ACTIVE;
        // (RULE4) Low-power request held
        else if (en_s && !lpm_n_s && cnt_r >= CNT_W'(HOLD_CYC))
          state_nxt = SPM_LOWPOWER;
      end
      SPM_ACTIVE: begin
        // (RULE19) Overcurrent or short trips
        if (trip_act) state_nxt = SPM_FAULT;
        // (RULE6) Request to low power
        else if (!lpm_n_s) state_nxt = SPM_LOWPOWER;
      end
      SPM_LOWPOWER: begin
        // (RULE9) Request released
        if (lpm_n_s) state_nxt = SPM_ACTIVE;
        // (RULE14) Short during bypass ramp
        else if (lwu_s || (bshort_s && !bgood_s)) state_nxt = SPM_WAKEUP;
      end
      SPM_WAKEUP: begin
        // (RULE15) Short in wakeup
        if (mshort_s) state_nxt = SPM_FAULT;
        // (RULE11) Wait for request release
        else if (lpm_n_s) state_nxt = SPM_ACTIVE;
      end
      SPM_FAULT: begin
        // (RULE22) Latch clear events
        if (LATCH_OFF_MODE && clear_latch)
          state_nxt = lpm_n_s ? SPM_ACTIVE : SPM_LOWPOWER;
        // (RULE21) Retry after full timer count
        else if (!LATCH_OFF_MODE && retry_r == 6'(RETRY_CNT))
          state_nxt = SPM_ACTIVE;
      end
      default: state_nxt = SPM_POWERDOWN;
    endcase
    // (RULE2) Supply loss overrides all
    if (!por_s)
      state_nxt = SPM_POWERDOWN;
    // (RULE3) Enable low means shutdown
    else if (!en_s && state_r != SPM_POWERDOWN)
      state_nxt = SPM_SHUTDOWN;
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) state_r <= SPM_POWERDOWN;
    else          state_r <= state_nxt;
  end

  // Shutdown hold timer and retry period timer (2 * HALF_CYC cycles) share one counter
  always_ff @(posedge CLK) begin
    if (!RESET_N)
      cnt_r <= '0;
    else if (state_r != state_nxt)
      cnt_r <= '0;
    else if (state_r == SPM_SHUTDOWN && en_s && !lpm_n_s) begin
      // (RULE23) Request hold count
      if (cnt_r != '1) cnt_r <= cnt_r + CNT_W'(1);
    end else if (state_r == SPM_FAULT && !LATCH_OFF_MODE) begin
      if (cnt_r >= CNT_W'(2 * HALF_CYC - 1)) cnt_r <= '0;
      else cnt_r <= cnt_r + CNT_W'(1);
    end else
      cnt_r <= '0;
  end

  // (RULE21) Count charge-discharge cycles
  always_ff @(posedge CLK) begin
    if (!RESET_N || state_r != SPM_FAULT)
      retry_r <= '0;
    else if (!LATCH_OFF_MODE && cnt_r == CNT_W'(2 * HALF_CYC - 1))
      retry_r <= retry_r + 6'd1;
  end

  // ****************************************************************
  // Fault indication
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      fault_r    <= 1'b0;
      retrying_r <= 1'b0;
      flt_dly_r  <= '0;
    end else if (state_nxt == SPM_FAULT) begin
      // Trip and latch
      fault_r    <= 1'b1;
      retrying_r <= 1'b0;
      flt_dly_r  <= '0;
    end else if (state_r == SPM_FAULT && !LATCH_OFF_MODE) begin
      // Retry: hold fault for the release delay
      retrying_r <= 1'b1;
    end else if (retrying_r) begin
      // (RULE21) Delayed fault release
      if (flt_dly_r == 5'(FLT_DELAY_CYC - 1)) begin
        fault_r    <= 1'b0;
        retrying_r <= 1'b0;
      end
      flt_dly_r <= flt_dly_r + 5'd1;
    end else begin
      fault_r <= 1'b0;
    end
  end

  // Pump undervoltage only counts where protections run
  wire pump_fault = !pump_s &&
       (state_r == SPM_ACTIVE || state_r == SPM_LOWPOWER ||
        state_r == SPM_WAKEUP);

  // ****************************************************************
  // Drive outputs
  // ****************************************************************
  logic main_nxt, byp_nxt, wake_nxt;
  always_comb begin
    main_nxt = 1'b0;
    byp_nxt  = 1'b0;
    wake_nxt = 1'b0;
    unique case (state_r)
      // (RULE16) Main follows switch input
      SPM_ACTIVE:   main_nxt = inp_s;
      // (RULE8) Bypass path only
      SPM_LOWPOWER: begin
        byp_nxt  = 1'b1;
        wake_nxt = 1'b1;
      end
      // (RULE10) Main first, bypass off after full on
      SPM_WAKEUP: begin
        main_nxt = 1'b1;
        byp_nxt  = !mfull_s;
        wake_nxt = !mfull_s;
      end
      default: ;
    endcase
    // (RULE17) Undervoltage drops drives
    // (RULE12) Same for bypass in low power
    // (RULE18) Pump undervoltage drops drives
    // (RULE13) Covers the bypass path too
    if (!uv_s || pump_fault) begin
      main_nxt = 1'b0;
      byp_nxt  = 1'b0;
    end
    // (RULE20) Short kills main immediately
    // (RULE15) And bypass within response
    if (state_nxt == SPM_FAULT) begin
      main_nxt = 1'b0;
      byp_nxt  = 1'b0;
    end
    // (RULE1) Enable low forces both off
    if (!en_s || !por_s) begin
      main_nxt = 1'b0;
      byp_nxt  = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      MAIN_GATE_DRIVE     <= 1'b0;
      BYPASS_GATE_DRIVE   <= 1'b0;
      LINK.wake_output    <= 1'b0;
      LINK.fault_output_n <= 1'b1;
      PUMP_ENABLE         <= 1'b0;
      PROTECT_ENABLE      <= 1'b0;
    end else begin
      MAIN_GATE_DRIVE     <= main_nxt;
      BYPASS_GATE_DRIVE   <= byp_nxt;
      LINK.wake_output    <= wake_nxt;
      LINK.fault_output_n <= !(fault_r || pump_fault);
      PUMP_ENABLE    <= state_r inside {SPM_ACTIVE, SPM_LOWPOWER,
                                        SPM_WAKEUP, SPM_FAULT};
      PROTECT_ENABLE <= state_r inside {SPM_ACTIVE, SPM_LOWPOWER,
                                        SPM_WAKEUP};
    end
  end

  assign MODE = state_r;
endmodule
`default_nettype wire

/* File: spm_host.sv */
// Host end: sequences enable, low-power request and switch pins
`timescale 1ns/1ps
`default_nettype none
module spm_host
  import spm_pkg::*;
#(
  parameter int HOLD_CYC = LPM_HOLD_CYC,
  parameter int LAG_CYC  = INP_LAG_CYC
) (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RESET_N,
  // User requests (levels)
  input  wire logic ENABLE_REQ,
  input  wire logic LOW_POWER_REQ,
  input  wire logic SWITCH_REQ,
  // Status back to user
  output logic      FAULT,
  output logic      WAKE,
  // Pins
  spm_link_if.host  LINK
);
  logic [CNT_W-1:0] lag_r;
  logic             lp_q_r;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      LINK.enable_undervoltage_input <= 1'b0;
      LINK.low_power_request_n       <= 1'b1;
      // (RULE4) Request and enable raised together
      // (RULE5) Raised together when request idle
    end else begin
      LINK.enable_undervoltage_input <= ENABLE_REQ;
      LINK.low_power_request_n       <= !LOW_POWER_REQ;
    end
  end

  // (RULE7) Switch drop delayed after request
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      lag_r  <= '0;
      lp_q_r <= 1'b0;
      LINK.main_switch_input <= 1'b0;
    end else begin
      lp_q_r <= LOW_POWER_REQ;
      if (LOW_POWER_REQ && !lp_q_r)
        lag_r <= CNT_W'(LAG_CYC);
      else if (lag_r != '0)
        lag_r <= lag_r - CNT_W'(1);
      if (SWITCH_REQ)
        LINK.main_switch_input <= 1'b1;
      else if (lag_r == '0 && !(LOW_POWER_REQ && !lp_q_r))
        LINK.main_switch_input <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      FAULT <= 1'b0;
      WAKE  <= 1'b0;
    end else begin
      FAULT <= !LINK.fault_output_n;
      WAKE  <= LINK.wake_output;
    end
  end
endmodule
`default_nettype wire

/* File: spm_link_properties.sv */
// Assertions watching the link and drive outputs of the mode machine
`timescale 1ns/1ps
`default_nettype none
module spm_link_properties
  import spm_pkg::*;
(
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RESET_N,
  // Link pins
  input wire logic       enable_undervoltage_input,
  input wire logic       low_power_request_n,
  input wire logic       main_switch_input,
  input wire logic       fault_output_n,
  input wire logic       wake_output,
  // Comparators and configuration
  input wire logic       POWERON_OK,
  input wire logic       UNDERVOLTAGE_OK,
  input wire logic       PUMP_OK,
  input wire logic       LATCH_OFF_MODE,
  // Drives and state
  input wire logic       MAIN_GATE_DRIVE,
  input wire logic       BYPASS_GATE_DRIVE,
  input wire logic       PUMP_ENABLE,
  input wire logic       PROTECT_ENABLE,
  input wire logic [2:0] MODE
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  a_enable_gates_off: assert property (
    !enable_undervoltage_input [*5] |-> !MAIN_GATE_DRIVE && !BYPASS_GATE_DRIVE)
    else $error("gate drive on with enable low");
  a_powerdown_all_off: assert property (
    !POWERON_OK [*5] |-> MODE == SPM_POWERDOWN && !PUMP_ENABLE && !PROTECT_ENABLE)
    else $error("not powered down with supply low");
  a_lowpower_drives: assert property (
    (MODE == SPM_LOWPOWER && UNDERVOLTAGE_OK && PUMP_OK) [*6]
    |-> BYPASS_GATE_DRIVE && !MAIN_GATE_DRIVE && wake_output)
    else $error("low power drives wrong");
  a_active_main_follows: assert property (
    (MODE == SPM_ACTIVE && UNDERVOLTAGE_OK && PUMP_OK
     && $stable(main_switch_input)) [*6]
    |-> MAIN_GATE_DRIVE == main_switch_input && !BYPASS_GATE_DRIVE && !wake_output)
    else $error("active drives wrong");
  a_wakeup_main_on: assert property (
    $rose(MODE == SPM_WAKEUP) |-> ##[0:2] MAIN_GATE_DRIVE)
    else $error("main drive late in wakeup");
  a_bypass_after_main: assert property (
    $fell(BYPASS_GATE_DRIVE) && MODE == SPM_WAKEUP |-> MAIN_GATE_DRIVE)
    else $error("bypass off before main on");
  a_wakeup_holds: assert property (
    (MODE == SPM_WAKEUP && !low_power_request_n) [*4] |=> MODE != SPM_ACTIVE)
    else $error("left wakeup with request held");
  a_fault_entry: assert property (
    $rose(MODE == SPM_FAULT)
    |-> !MAIN_GATE_DRIVE && !BYPASS_GATE_DRIVE ##1 !fault_output_n)
    else $error("fault entry wrong");
  a_retry_release: assert property (
    $fell(MODE == SPM_FAULT) && !LATCH_OFF_MODE
    |-> !fault_output_n [*8] ##[1:12] fault_output_n)
    else $error("fault release delay wrong");
  a_active_to_lowpower: assert property (
    (MODE == SPM_ACTIVE && !low_power_request_n && enable_undervoltage_input) [*3]
    |-> ##[1:3] MODE == SPM_LOWPOWER)
    else $error("request ignored in active");
endmodule
`default_nettype wire

/* File: switch_power_mode_fsm_tb.sv */
// Bench joining the mode machine and its host end across the link
`timescale 1ns/1ps
`default_nettype none
module switch_power_mode_fsm_tb;
  import spm_pkg::*;
  localparam int HOLD = 20;
  localparam int LAG  = 5;
  logic       clk, reset_n, pwr_ok, uv_ok, pump_ok, wake_ev, byp_short;
  logic       byp_good, main_short, oc_done, main_full, latch_off;
  logic       en_req, lp_req, sw_req, fault, wake, main_drv, byp_drv;
  logic       pump_en, prot_en;
  logic [2:0] mode;
  logic [3:0] drv;
  int         err_count, tests_run, k;
  assign drv = {main_drv, byp_drv, wake, fault};
  spm_link_if link ();
  spm_device #(.HOLD_CYC(HOLD), .RETRY_CNT(2), .HALF_CYC(4)) u_spm_device (
    .CLK(clk), .RESET_N(reset_n), .LINK(link), .POWERON_OK(pwr_ok),
    .UNDERVOLTAGE_OK(uv_ok), .PUMP_OK(pump_ok), .LOAD_WAKEUP_EVENT(wake_ev),
    .BYPASS_SHORT_EVENT(byp_short), .BYPASS_GATE_GOOD(byp_good),
    .MAIN_SHORT_EVENT(main_short), .OVERCURRENT_EXPIRED(oc_done),
    .MAIN_GATE_FULL(main_full), .LATCH_OFF_MODE(latch_off),
    .MAIN_GATE_DRIVE(main_drv), .BYPASS_GATE_DRIVE(byp_drv),
    .PUMP_ENABLE(pump_en), .PROTECT_ENABLE(prot_en), .MODE(mode));
  spm_host #(.HOLD_CYC(HOLD), .LAG_CYC(LAG)) u_spm_host (
    .CLK(clk), .RESET_N(reset_n), .ENABLE_REQ(en_req), .LOW_POWER_REQ(lp_req),
    .SWITCH_REQ(sw_req), .FAULT(fault), .WAKE(wake), .LINK(link));
  spm_link_properties u_spm_link_properties (
    .CLK(clk), .RESET_N(reset_n),
    .enable_undervoltage_input(link.enable_undervoltage_input),
    .low_power_request_n(link.low_power_request_n),
    .main_switch_input(link.main_switch_input),
    .fault_output_n(link.fault_output_n), .wake_output(link.wake_output),
    .POWERON_OK(pwr_ok), .UNDERVOLTAGE_OK(uv_ok), .PUMP_OK(pump_ok),
    .LATCH_OFF_MODE(latch_off), .MAIN_GATE_DRIVE(main_drv),
    .BYPASS_GATE_DRIVE(byp_drv), .PUMP_ENABLE(pump_en),
    .PROTECT_ENABLE(prot_en), .MODE(mode));

  always #10 clk = ~clk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded poll so a stuck state machine cannot hang the run
  task automatic wait_mode(input logic [2:0] m);
    int i;
    for (i = 0; i < 60 && mode !== m; i++) @(negedge clk);
    check({1'b0, mode}, {1'b0, m});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_power();
    wait_mode(SPM_POWERDOWN);
    check({pump_en, prot_en, main_drv, byp_drv}, 4'h0);
    @(posedge clk);
    pwr_ok <= 1'b1;
    wait_mode(SPM_SHUTDOWN);
    cyc(3);
    check({pump_en, prot_en, main_drv, byp_drv}, 4'h0);
  endtask
  task automatic t_enter_lp();
    @(posedge clk);
    en_req <= 1'b1;
    lp_req <= 1'b1;
    cyc(HOLD / 2);
    check({1'b0, mode}, {1'b0, SPM_SHUTDOWN});
    wait_mode(SPM_LOWPOWER);
    cyc(3);
    check(drv, 4'b0110);
    check({pump_en, 3'h0}, 4'h8);
  endtask
  task automatic t_lp_protect();
    @(posedge clk);
    uv_ok <= 1'b0;
    cyc(6);
    check({main_drv, byp_drv, 2'h0}, 4'h0);
    @(posedge clk);
    uv_ok <= 1'b1;
    pump_ok <= 1'b0;
    cyc(8);
    check({main_drv, byp_drv, 1'b0, fault}, 4'h1);
    @(posedge clk);
    pump_ok <= 1'b1;
    cyc(8);
    check(drv, 4'b0110);
  endtask
  task automatic t_lp_to_active();
    @(posedge clk);
    lp_req <= 1'b0;
    sw_req <= 1'b1;
    wait_mode(SPM_ACTIVE);
    cyc(3);
    check(drv, 4'b1000);
    check({pump_en, prot_en, 2'h0}, 4'hC);
    @(posedge clk);
    sw_req <= 1'b0;
    cyc(8);
    check(drv, 4'b0000);
    @(posedge clk);
    sw_req <= 1'b1;
    cyc(8);
  endtask
  task automatic t_to_lp();
    int i;
    @(posedge clk);
    lp_req <= 1'b1;
    sw_req <= 1'b0;
    for (i = 0; i < 20 && link.low_power_request_n !== 1'b0; i++) cyc(1);
    cyc(LAG - 1);
    check({3'h0, link.main_switch_input}, 4'h1);
    wait_mode(SPM_LOWPOWER);
    cyc(3);
  endtask
  task automatic t_wakeup();
    @(posedge clk);
    wake_ev <= 1'b1;
    wait_mode(SPM_WAKEUP);
    cyc(2);
    check(drv, 4'b1110);
    @(posedge clk);
    main_full <= 1'b1;
    cyc(8);
    check(drv, 4'b1000);
    @(posedge clk);
    wake_ev <= 1'b0;
    cyc(20);
    check({1'b0, mode}, {1'b0, SPM_WAKEUP});
    @(posedge clk);
    lp_req <= 1'b0;
    sw_req <= 1'b1;
    wait_mode(SPM_ACTIVE);
    cyc(8);
  endtask
  task automatic t_active_protect();
    for (k = 0; k < 2; k++) begin
      @(posedge clk);
      if (k == 0) uv_ok <= 1'b0;
      else pump_ok <= 1'b0;
      cyc(8);
      check({main_drv, 3'h0}, 4'h0);
      check({3'h0, fault}, 4'(k));
      @(posedge clk);
      uv_ok <= 1'b1;
      pump_ok <= 1'b1;
      cyc(8);
      check({main_drv, 3'h0}, 4'h8);
    end
  endtask
  task automatic t_latch();
    @(posedge clk);
    latch_off <= 1'b1;
    for (k = 0; k < 2; k++) begin
      if (k == 0) main_short <= 1'b1;
      else oc_done <= 1'b1;
      wait_mode(SPM_FAULT);
      cyc(3);
      check(drv, 4'b0001);
      @(posedge clk);
      main_short <= 1'b0;
      oc_done <= 1'b0;
      cyc(30);
      check({1'b0, mode}, {1'b0, SPM_FAULT});
      @(posedge clk);
      sw_req <= 1'b0;
      wait_mode(SPM_ACTIVE);
      @(posedge clk);
      sw_req <= 1'b1;
      cyc(8);
    end
  endtask
  task automatic t_retry();
    @(posedge clk);
    latch_off <= 1'b0;
    lp_req <= 1'b1;
    sw_req <= 1'b0;
    wait_mode(SPM_LOWPOWER);
    @(posedge clk);
    byp_good <= 1'b0;
    byp_short <= 1'b1;
    wait_mode(SPM_WAKEUP);
    cyc(2);
    check({main_drv, 3'h0}, 4'h8);
    @(posedge clk);
    main_short <= 1'b1;
    wait_mode(SPM_FAULT);
    cyc(2);
    check({main_drv, byp_drv, 1'b0, fault}, 4'h1);
    @(posedge clk);
    main_short <= 1'b0;
    byp_short <= 1'b0;
    byp_good <= 1'b1;
    lp_req <= 1'b0;
    sw_req <= 1'b1;
    cyc(5);
    check({1'b0, mode}, {1'b0, SPM_FAULT});
    wait_mode(SPM_ACTIVE);
    check({3'h0, fault}, 4'h1);
    cyc(24);
    check(drv, 4'b1000);
  endtask

  initial begin
    {clk, reset_n, pwr_ok, wake_ev, byp_short, main_short, oc_done} = '0;
    {main_full, latch_off, en_req, lp_req, sw_req} = '0;
    {uv_ok, pump_ok, byp_good} = 3'h7;
    err_count = 0;
    tests_run = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    t_power();
    t_enter_lp();
    t_lp_protect();
    t_lp_to_active();
    t_to_lp();
    t_wakeup();
    t_active_protect();
    t_latch();
    t_retry();
    @(posedge clk);
    en_req <= 1'b0;
    wait_mode(SPM_SHUTDOWN);
    cyc(2);
    check({main_drv, byp_drv, 2'h0}, 4'h0);
    @(posedge clk);
    en_req <= 1'b1;
    wait_mode(SPM_ACTIVE);
    cyc(4);
    check(drv, 4'b1000);
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire
